// ---- src/irq_ctl_pkg.sv ----
/*
  constants, field layouts and carrier types of the eight-level interrupt controller.
  assumes one 200 MHz system clock shared with the cpu core and the peripherals.
*/
package irq_ctl_pkg;
  localparam int          LEVELS        = 8;
  localparam int          HW_SOURCES    = 11;
  localparam logic [11:0] VEC_STEP      = 12'h0040;
  localparam logic [11:0] VEC_TOP       = 12'h01e0;
  localparam logic [7:0]  OPC_BASE      = 8'hc0;
  localparam logic [7:0]  RST_PENDING   = 8'h00;
  localparam logic [7:0]  RST_ACTIVE    = 8'h00;
  localparam logic        RST_IE        = 1'b0;
  localparam int          MC_CLOCKS     = 2;
  // i/o addresses (4-bit primary space)
  localparam logic [3:0]  IO_SWI_LO     = 4'h0;
  localparam logic [3:0]  IO_SWI_HI     = 4'h1;
  localparam logic [3:0]  IO_PEND_LO    = 4'h2;
  localparam logic [3:0]  IO_PEND_HI    = 4'h3;
  localparam logic [3:0]  IO_ACT_LO     = 4'h4;
  localparam logic [3:0]  IO_ACT_HI     = 4'h5;
  localparam logic [3:0]  IO_FLAGS      = 4'h6;
  // source index per level; level 0 is software only
  localparam int          SRC_L1_A      = 0;
  localparam int          SRC_L1_B      = 1;
  localparam int          SRC_L2        = 2;
  localparam int          SRC_L3        = 3;
  localparam int          SRC_L4        = 4;
  localparam int          SRC_L5_CMP1   = 5;
  localparam int          SRC_L5_CMP2   = 6;
  localparam int          SRC_L5_EDGE   = 7;
  localparam int          SRC_L6_A      = 8;
  localparam int          SRC_L6_B      = 9;
  localparam int          SRC_L7        = 10;

  typedef struct packed {
    logic [7:0]  opcode;
    logic [11:0] vector;
  } ack_s;

  typedef struct packed {
    logic                  phase;
    logic                  ie;
    logic [LEVELS-1:0]     pending;
    logic [LEVELS-1:0]     active;
    logic [HW_SOURCES-1:0] hold;
    logic [3:0]            swi_lo;
    logic                  irq_req;
    logic                  ack;
    ack_s                  ack_info;
    logic [3:0]            rdata;
  } ctl_state_s;
endpackage : irq_ctl_pkg

// ---- src/irq_ctl.sv ----
/*
  eight-level prioritised interrupt controller of the 4-bit stack core.
  assumes the core drives instruction strobes and the i/o bus on i_clk, and that
  peripheral request pulses and their mask bits are synchronous to i_clk.
*/
// Behaviour
// - global enable gates every service start; reset is not affected by it
// - enable cleared by reset or disable; set only by enable or sleep
// - eight levels, fixed priorities, own vector; hardware or software sources
// - one 8-bit pending and one 8-bit active register, bit per level
// - requests sampled into pending every machine cycle that is not i/o
// - cpu signalled only when no higher level is active
// - acknowledge runs a short vector call and pushes the current pc
// - return clears serviced level in pending and active, pc from stack
// - with enable clear requests still latch; dispatch waits for enable
// - repeat request on a set pending bit merges; no counting
// - request to service start takes 3 to 4 system clocks at an instruction boundary
// - a machine cycle is two system clocks
// - vectors 040h upward in 040h steps to 1C0h; top level 1E0h
// - each level injects its own one-byte short call opcode
// - soft interrupt writes two popped nibbles to pending over i/o bus
// - soft requests are prioritised and retired like hardware ones
// - eleven hardware sources on seven levels, each individually maskable
// - third timer level shared by compare one, compare two, edge event
// - i/o bus reaches one of 16 primary addresses
// - master reset clears enable, pending and active
module irq_ctl
  import irq_ctl_pkg::*;
(
  input  wire logic                  i_clk,       // system clock
  input  wire logic                  i_rst,       // master reset, async high
  input  wire logic [HW_SOURCES-1:0] i_hw_src,    // peripheral request pulses
  input  wire logic [HW_SOURCES-1:0] i_src_mask,  // 1 = source masked
  input  wire logic                  i_io_cycle,  // current cycle is an i/o access
  input  wire logic                  i_instr_end, // instruction boundary
  input  wire logic                  i_di,        // disable instruction
  input  wire logic                  i_ei,        // enable instruction
  input  wire logic                  i_sleep,     // sleep instruction
  input  wire logic                  i_rti,       // return-from-interrupt
  input  wire logic [3:0]            i_io_addr,   // i/o bus address
  input  wire logic [3:0]            i_io_wdata,  // i/o bus write nibble
  input  wire logic                  i_io_wr,     // i/o write strobe
  input  wire logic                  i_io_rd,     // i/o read strobe
  output logic [3:0]                 o_io_rdata,  // read nibble, one cycle later
  output logic                       o_irq_req,   // interrupt signalled to cpu
  output logic                       o_ack,       // acknowledge cycle pulse
  output logic                       o_push_pc,   // push pc to return stack
  output logic [7:0]                 o_short_vector_call_op,  // injected short call opcode
  output logic [11:0]                o_vector,    // service routine address
  output logic                       o_ie,        // global enable flag
  output logic [7:0]                 o_pending,   // pending register
  output logic [7:0]                 o_active     // active register
);

  ctl_state_s st;
  ctl_state_s next_st;

  // highest set bit; valid flag in bit 3
  function automatic logic [3:0] top_level(input logic [7:0] v);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 0; i < LEVELS; i++) begin
      if (v[i]) begin
        r = {1'b1, 3'(i)};
      end
    end
    return r;
  endfunction : top_level

  function automatic ack_s level_ack(input logic [2:0] lvl);
    ack_s a;
    a.vector = (lvl == 3'd7) ? VEC_TOP : 12'(VEC_STEP * (12'(lvl) + 12'd1));
    a.opcode = OPC_BASE | 8'(a.vector >> 3);
    return a;
  endfunction : level_ack

  logic [HW_SOURCES-1:0] src_live;
  logic [LEVELS-1:0]     src_level;
  logic [LEVELS-1:0]     pend_hold;
  logic [3:0]            cand;
  logic [3:0]            act_top;
  logic                  cand_ok;
  logic                  sample;
  logic                  take_ack;
  logic [LEVELS-1:0]     cand_bit;
  logic [LEVELS-1:0]     rti_bit;
  logic [LEVELS-1:0]     swi_bits;

  assign src_live = i_hw_src & ~i_src_mask;

  // fold eleven sources onto seven levels
  always_comb begin
    src_level    = '0;
    pend_hold    = '0;
    src_level[1] = st.hold[SRC_L1_A] | st.hold[SRC_L1_B];
    src_level[2] = st.hold[SRC_L2];
    src_level[3] = st.hold[SRC_L3];
    src_level[4] = st.hold[SRC_L4];
    src_level[5] = st.hold[SRC_L5_CMP1] | st.hold[SRC_L5_CMP2] | st.hold[SRC_L5_EDGE];
    src_level[6] = st.hold[SRC_L6_A] | st.hold[SRC_L6_B];
    src_level[7] = st.hold[SRC_L7];
    pend_hold    = st.pending & ~st.active;
  end

  // a level already active keeps its pending bit until return, so it is excluded
  assign cand     = top_level(pend_hold);
  assign act_top  = top_level(st.active);
  assign cand_ok  = cand[3] && (!act_top[3] || cand[2:0] > act_top[2:0]);
  assign sample   = st.phase && !i_io_cycle;
  assign take_ack = st.irq_req && cand_ok && st.ie && st.phase && i_instr_end && !st.ack;
  assign cand_bit = take_ack ? (8'h01 << cand[2:0]) : 8'h00;
  assign rti_bit  = (i_rti && act_top[3]) ? (8'h01 << act_top[2:0]) : 8'h00;
  assign swi_bits = (i_io_wr && i_io_addr == IO_SWI_HI) ? {i_io_wdata, st.swi_lo} : 8'h00;

  always_comb begin
    next_st       = st;
    next_st.phase = ~st.phase;
    next_st.ack   = 1'b0;
    next_st.rdata = 4'h0;

    // pulses between sample points are held; a new pulse beats the clear
    next_st.hold = (sample ? '0 : st.hold) | src_live;

    // enable flag: disable wins over a simultaneous set
    if (i_di) begin
      next_st.ie = 1'b0;
    end else if (i_ei || i_sleep) begin
      next_st.ie = 1'b1;
    end

    // set wins over retirement; a repeat on a set bit is simply absorbed
    next_st.pending = (st.pending & ~rti_bit)
                    | (sample ? src_level : 8'h00) | swi_bits;
    next_st.active  = (st.active & ~rti_bit) | cand_bit;

    next_st.irq_req = cand_ok && !take_ack;
    if (take_ack) begin
      next_st.ack      = 1'b1;
      next_st.ack_info = level_ack(cand[2:0]);
    end

    if (i_io_wr && i_io_addr == IO_SWI_LO) begin
      next_st.swi_lo = i_io_wdata;
    end

    if (i_io_rd) begin
      case (i_io_addr)
        IO_SWI_LO:  next_st.rdata = st.swi_lo;
        IO_PEND_LO: next_st.rdata = st.pending[3:0];
        IO_PEND_HI: next_st.rdata = st.pending[7:4];
        IO_ACT_LO:  next_st.rdata = st.active[3:0];
        IO_ACT_HI:  next_st.rdata = st.active[7:4];
        IO_FLAGS:   next_st.rdata = {1'b0, act_top[3], st.irq_req, st.ie};
        default:    next_st.rdata = 4'h0;
      endcase
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st          <= '0;
      st.ie       <= RST_IE;
      st.pending  <= RST_PENDING;
      st.active   <= RST_ACTIVE;
    end else begin
      st <= next_st;
    end
  end

  assign o_io_rdata = st.rdata;
  assign o_irq_req  = st.irq_req;
  assign o_ack      = st.ack;
  assign o_push_pc  = st.ack;
  assign o_short_vector_call_op = st.ack_info.opcode;
  assign o_vector   = st.ack_info.vector;
  assign o_ie       = st.ie;
  assign o_pending  = st.pending;
  assign o_active   = st.active;

  // assertions
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  property p_ie_clear;
    i_di |=> !o_ie;
  endproperty
  a_ie_clear: assert property (p_ie_clear) else $error("enable not cleared by disable");

  property p_ie_set;
    (i_ei || i_sleep) && !i_di |=> o_ie;
  endproperty
  a_ie_set: assert property (p_ie_set) else $error("enable not set");

  property p_ack_gated;
    o_ack |-> $past(o_ie) && $past(o_irq_req);
  endproperty
  a_ack_gated: assert property (p_ack_gated) else $error("ack without enable or request");

  property p_ie_stays;
    !o_ie && !i_ei && !i_sleep |=> !o_ie;
  endproperty
  a_ie_stays: assert property (p_ie_stays) else $error("enable set without instruction");

  property p_phase;
    st.phase |=> !st.phase ##1 st.phase;
  endproperty
  a_phase: assert property (p_phase) else $error("machine cycle not two clocks");

  property p_opcode;
    o_ack |-> o_push_pc && o_short_vector_call_op == (OPC_BASE | 8'(o_vector >> 3));
  endproperty
  a_opcode: assert property (p_opcode) else $error("opcode does not match vector");

  property p_vector_top;
    o_ack && o_active[7] && !$past(st.active[7]) |-> o_vector == VEC_TOP;
  endproperty
  a_vector_top: assert property (p_vector_top) else $error("top level vector wrong");

  property p_sample;
    sample && st.hold[SRC_L7] |=> o_pending[7];
  endproperty
  a_sample: assert property (p_sample) else $error("held request not latched");

  property p_swi;
    i_io_wr && i_io_addr == IO_SWI_HI && !i_rti |=> o_pending[7:4] ==
      ($past(o_pending[7:4]) | $past(i_io_wdata) | $past(sample ? src_level[7:4] : 4'h0));
  endproperty
  a_swi: assert property (p_swi) else $error("soft request not written");

  property p_rti;
    i_rti && act_top[3] |=> !o_active[$past(act_top[2:0])];
  endproperty
  a_rti: assert property (p_rti) else $error("return did not retire a level");

  property p_no_lower;
    o_ack |-> !($past(act_top[3]) && $past(cand[2:0]) <= $past(act_top[2:0]));
  endproperty
  a_no_lower: assert property (p_no_lower) else $error("acked under higher active level");

  property p_dispatch;
    o_irq_req && cand_ok && o_ie && !i_di && i_instr_end && st.phase && !o_ack |=> o_ack;
  endproperty
  a_dispatch: assert property (p_dispatch) else $error("ready request not acknowledged");

  property p_io_quiet;
    i_io_cycle && !(i_io_wr && i_io_addr == IO_SWI_HI) |=> (o_pending & ~$past(o_pending)) == 8'h00;
  endproperty
  a_io_quiet: assert property (p_io_quiet) else $error("request latched in i/o cycle");

  property p_hold_masked;
    sample && i_src_mask[SRC_L7] && i_hw_src[SRC_L7] |=> !st.hold[SRC_L7];
  endproperty
  a_hold_masked: assert property (p_hold_masked) else $error("masked source held");

  property p_pend_clear;
    i_rti && act_top[3] && !sample && !(i_io_wr && i_io_addr == IO_SWI_HI) |=> !o_pending[$past(act_top[2:0])];
  endproperty
  a_pend_clear: assert property (p_pend_clear) else $error("return left pending bit");

  property p_defer;
    sample && st.hold[SRC_L2] && !o_ie |=> o_pending[2];
  endproperty
  a_defer: assert property (p_defer) else $error("request lost while disabled");

  property p_merge;
    o_pending[2] && !i_rti |=> o_pending[2];
  endproperty
  a_merge: assert property (p_merge) else $error("pending bit dropped without return");

  property p_irq_drop;
    o_ack |-> !o_irq_req;
  endproperty
  a_irq_drop: assert property (p_irq_drop) else $error("request still signalled in ack");

  property p_push;
    o_push_pc == o_ack;
  endproperty
  a_push: assert property (p_push) else $error("push not aligned with ack");

  property p_rdata_idle;
    !$past(i_io_rd) |-> o_io_rdata == 4'h0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside its cycle");

  property p_unmapped;
    i_io_rd && i_io_addr > IO_FLAGS |=> o_io_rdata == 4'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

  property p_highest;
    o_ack |-> ($past(pend_hold) >> $past(cand[2:0])) == 8'h01;
  endproperty
  a_highest: assert property (p_highest) else $error("lower level acked first");

  property p_vec_grid;
    o_ack && o_vector != VEC_TOP |-> o_vector[5:0] == 6'h00 && o_vector != 12'h0000 && o_vector < VEC_TOP;
  endproperty
  a_vec_grid: assert property (p_vec_grid) else $error("vector off grid");

  property p_act_in_pend;
    (o_active & ~o_pending) == 8'h00;
  endproperty
  a_act_in_pend: assert property (p_act_in_pend) else $error("active level not pending");

  property p_swi_lo;
    i_io_wr && i_io_addr == IO_SWI_LO |=> st.swi_lo == $past(i_io_wdata);
  endproperty
  a_swi_lo: assert property (p_swi_lo) else $error("soft low nibble not stored");

  property p_rd_swi;
    i_io_rd && i_io_addr == IO_SWI_LO |=> o_io_rdata == $past(st.swi_lo);
  endproperty
  a_rd_swi: assert property (p_rd_swi) else $error("soft nibble read wrong");

  property p_rd_pend;
    i_io_rd && i_io_addr == IO_PEND_HI |=> o_io_rdata == $past(o_pending[7:4]);
  endproperty
  a_rd_pend: assert property (p_rd_pend) else $error("pending high read wrong");

  property p_rd_act;
    i_io_rd && i_io_addr == IO_ACT_LO |=> o_io_rdata == $past(o_active[3:0]);
  endproperty
  a_rd_act: assert property (p_rd_act) else $error("active low read wrong");

  property p_rd_flags;
    i_io_rd && i_io_addr == IO_FLAGS |=> o_io_rdata == {1'b0, $past(o_active != 8'h00), $past(o_irq_req), $past(o_ie)};
  endproperty
  a_rd_flags: assert property (p_rd_flags) else $error("flags read wrong");

  property p_vec_hold;
    !o_ack |-> $stable(o_vector) && $stable(o_short_vector_call_op);
  endproperty
  a_vec_hold: assert property (p_vec_hold) else $error("call info changed without ack");

  property p_act_grow;
    !o_ack |-> (o_active & ~$past(o_active)) == 8'h00;
  endproperty
  a_act_grow: assert property (p_act_grow) else $error("active set without ack");

  property p_l5_edge;
    sample && st.hold[SRC_L5_EDGE] |=> o_pending[5];
  endproperty
  a_l5_edge: assert property (p_l5_edge) else $error("edge event not on shared level");

  property p_l1_b;
    sample && st.hold[SRC_L1_B] |=> o_pending[1];
  endproperty
  a_l1_b: assert property (p_l1_b) else $error("second level one source lost");

  property p_l6_b;
    sample && st.hold[SRC_L6_B] |=> o_pending[6];
  endproperty
  a_l6_b: assert property (p_l6_b) else $error("second level six source lost");

  property p_soft_like;
    i_io_wr && i_io_addr == IO_SWI_HI && i_io_wdata[3] |=> o_pending[7];
  endproperty
  a_soft_like: assert property (p_soft_like) else $error("soft top level not pending");

  property p_take_boundary;
    o_ack |-> $past(i_instr_end) && $past(st.phase);
  endproperty
  a_take_boundary: assert property (p_take_boundary) else $error("ack off instruction boundary");

  c_ack:    cover property (o_ack);
  c_nested: cover property (o_ack && $countones(o_active) > 1);
  c_rti:    cover property (i_rti && act_top[3]);
  c_swi:    cover property (i_io_wr && i_io_addr == IO_SWI_HI && i_io_wdata != 4'h0);
  c_hold:   cover property (i_io_cycle && st.hold != '0);

endmodule : irq_ctl

// ---- verification/core_model.sv ----
/*
  behavioural cpu core facing the interrupt controller: return stack depth and return strobes.
  assumes the controller's clock; an instruction takes one machine cycle unless the bench stretches it.
*/
module core_model (
  input  wire logic i_clk,       // system clock
  input  wire logic i_rst,       // async reset
  input  wire logic i_push_pc,   // acknowledge push
  input  wire logic i_rti_req,   // bench asks for a return
  input  wire logic i_io_busy,   // bench asks for an i/o cycle
  input  wire logic i_long_op,   // bench asks for a multi-cycle instruction
  output logic       o_rti,       // return strobe
  output logic       o_io_cycle,  // i/o access flag
  output logic       o_instr_end, // instruction boundary
  output logic [3:0] o_depth      // return stack depth
);
  timeunit 1ns;
  timeprecision 1ps;
  assign o_instr_end = !i_long_op;
  assign o_io_cycle  = i_io_busy;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_depth <= 4'h0;
      o_rti   <= 1'b0;
    end else begin
      // an empty stack cannot return, so no stray strobe reaches the controller
      o_rti <= i_rti_req && (o_depth != 4'h0);
      if (i_push_pc) o_depth <= o_depth + 4'h1;
      else if (o_rti) o_depth <= o_depth - 4'h1;
    end
  end
endmodule : core_model

// ---- verification/tb_top.sv ----
/*
  self-checking bench of the interrupt controller with a behavioural core beside it.
  assumes the controller package and a 200 MHz clock.
*/
module tb_top
  import irq_ctl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic                  i_clk, i_rst, di, ei, sleep, io_wr, io_rd, rti_req, io_busy, long_op;
  logic                  irq_req, ack, push_pc, ie, return_from_irq_instruction, io_cycle, instr_end;
  logic [HW_SOURCES-1:0] hw_src, src_mask;
  logic [3:0]            io_addr, io_wdata, io_rdata, depth;
  logic [7:0]            short_vector_call_op, pending, active;
  logic [11:0]           vector;
  int                    fail_count = 0;
  int                    cmp_count = 0;
  irq_ctl DUT (.i_clk(i_clk), .i_rst(i_rst), .i_hw_src(hw_src), .i_src_mask(src_mask),
    .i_io_cycle(io_cycle), .i_instr_end(instr_end), .i_di(di), .i_ei(ei), .i_sleep(sleep),
    .i_rti(return_from_irq_instruction), .i_io_addr(io_addr), .i_io_wdata(io_wdata), .i_io_wr(io_wr), .i_io_rd(io_rd),
    .o_io_rdata(io_rdata), .o_irq_req(irq_req), .o_ack(ack), .o_push_pc(push_pc),
    .o_short_vector_call_op(short_vector_call_op), .o_vector(vector), .o_ie(ie), .o_pending(pending), .o_active(active));
  core_model core (.i_clk(i_clk), .i_rst(i_rst), .i_push_pc(push_pc), .i_rti_req(rti_req),
    .i_io_busy(io_busy), .i_long_op(long_op), .o_rti(return_from_irq_instruction), .o_io_cycle(io_cycle),
    .o_instr_end(instr_end), .o_depth(depth));
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic final_report;
    if (fail_count == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : final_report
  task automatic tick(input int n = 1);
    repeat (n) @(posedge i_clk);
  endtask : tick
  task automatic pulse(input logic [HW_SOURCES-1:0] m);
    hw_src <= m;
    tick();
    hw_src <= '0;
  endtask : pulse
  task automatic io(input logic wr, input logic [3:0] a, input logic [3:0] d, output logic [3:0] q);
    io_addr  <= a;
    io_wdata <= d;
    io_wr    <= wr;
    io_rd    <= !wr;
    tick();
    io_wr <= 1'b0;
    io_rd <= 1'b0;
    tick();
    q = io_rdata;
  endtask : io
  task automatic strobe_ie(input logic set);
    if (set) ei <= 1'b1;
    else di <= 1'b1;
    tick();
    ei <= 1'b0;
    di <= 1'b0;
    tick(2);
  endtask : strobe_ie
  task automatic wait_ack(input int lim);
    int n;
    n = 0;
    while (ack !== 1'b1) begin
      tick();
      n++;
      if (n > lim) begin
        fail_count++;
        $display("mismatch at %0t: no acknowledge", $time);
        final_report();
      end
    end
    chk(12'(push_pc), 12'h001);
  endtask : wait_ack
  task automatic no_ack(input int n);
    repeat (n) begin
      tick();
      chk(12'(ack), 12'h000);
    end
  endtask : no_ack
  task automatic do_rti;
    rti_req <= 1'b1;
    tick();
    rti_req <= 1'b0;
    tick(2);
  endtask : do_rti
  function automatic logic [11:0] vec_of(input int lvl);
    return (lvl == 7) ? VEC_TOP : 12'(lvl + 1) * VEC_STEP;
  endfunction : vec_of
  task automatic s_levels;
    int lv[HW_SOURCES] = '{1, 1, 2, 3, 4, 5, 5, 5, 6, 6, 7};
    strobe_ie(1'b1);
    for (int s = 0; s < HW_SOURCES; s++) begin
      pulse(11'h001 << s);
      wait_ack(8);
      chk(vector, vec_of(lv[s]));
      chk(12'(short_vector_call_op), 12'(12'h0c0 | (vec_of(lv[s]) >> 3)));
      chk(12'(active), 12'(9'h001 << lv[s]));
      tick();
      chk(12'(depth), 12'h001);
      do_rti();
      chk(12'(pending | active), 12'h000);
    end
  endtask : s_levels
  task automatic s_soft;
    logic [3:0] q;
    io(1'b1, IO_SWI_LO, 4'h1, q);
    io(1'b0, IO_SWI_LO, 4'h0, q);
    chk(12'(q), 12'h001);
    io(1'b1, IO_SWI_HI, 4'h0, q);
    wait_ack(12);
    chk(vector, 12'h0040);
    chk(12'(short_vector_call_op), 12'h00c8);
    do_rti();
  endtask : s_soft
  task automatic s_gate;
    strobe_ie(1'b0);
    chk(12'(ie), 12'h000);
    pulse(11'h001 << SRC_L2);
    no_ack(12);
    chk(12'(pending), 12'h004);
    chk(12'(irq_req), 12'h001);
    pulse(11'h001 << SRC_L2);
    sleep <= 1'b1;
    tick();
    sleep <= 1'b0;
    wait_ack(12);
    chk(12'(ie), 12'h001);
    do_rti();
    no_ack(12);
    chk(12'(pending), 12'h000);
  endtask : s_gate
  task automatic s_prio;
    logic [3:0] q;
    strobe_ie(1'b0);
    pulse((11'h001 << SRC_L3) | (11'h001 << SRC_L6_A));
    tick(6);
    chk(12'(pending), 12'h048);
    strobe_ie(1'b1);
    wait_ack(12);
    chk(vector, 12'h01c0);
    chk(12'(pending), 12'h048);
    chk(12'(irq_req), 12'h000);
    io(1'b0, IO_ACT_HI, 4'h0, q);
    chk(12'(q), 12'h004);
    io(1'b0, IO_PEND_HI, 4'h0, q);
    chk(12'(q), 12'h004);
    io(1'b0, IO_FLAGS, 4'h0, q);
    chk(12'(q), 12'h005);
    no_ack(12);
    do_rti();
    wait_ack(12);
    chk(vector, 12'h0100);
    io(1'b0, IO_ACT_LO, 4'h0, q);
    chk(12'(q), 12'h008);
    do_rti();
  endtask : s_prio
  task automatic s_io;
    logic [3:0] q;
    strobe_ie(1'b0);
    src_mask <= 11'h001 << SRC_L4;
    pulse(11'h001 << SRC_L4);
    tick(8);
    chk(12'(pending), 12'h000);
    src_mask <= '0;
    io_busy  <= 1'b1;
    hw_src   <= 11'h001 << SRC_L2;
    tick(6);
    chk(12'(pending), 12'h000);
    io_busy <= 1'b0;
    tick(4);
    hw_src <= '0;
    chk(12'(pending), 12'h004);
    io(1'b0, IO_PEND_LO, 4'h0, q);
    chk(12'(q), 12'h004);
    io(1'b0, 4'hf, 4'h0, q);
    chk(12'(q), 12'h000);
    strobe_ie(1'b1);
    wait_ack(12);
    do_rti();
  endtask : s_io
  // a stretched instruction defers the ack; then a reset lands in mid-service
  task automatic s_long;
    long_op <= 1'b1;
    pulse(11'h001 << SRC_L7);
    no_ack(8);
    long_op <= 1'b0;
    wait_ack(4);
    chk(vector, VEC_TOP);
    i_rst <= 1'b1;
    tick(2);
    i_rst <= 1'b0;
    tick(2);
    chk(12'({ie, pending, active} != 17'h0), 12'h000);
  endtask : s_long
  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end
  initial begin
    {i_rst, di, ei, sleep, io_wr, io_rd, rti_req, io_busy} = 8'h80;
    {hw_src, src_mask, io_addr, io_wdata, long_op} = '0;
    tick(16);
    i_rst <= 1'b0;
    tick(2);
    chk(12'({ie, pending, active} != 17'h0), 12'h000);
    s_levels();
    s_soft();
    s_gate();
    s_prio();
    s_io();
    s_long();
    final_report();
  end
endmodule : tb_top
